// >>> spm_top.sv
// Spindle protection monitor top: warnings, errors, release, overload timing.
// Assumes pins arrive asynchronous and Avalon-MM master on CORE_CLK.
// Overview of operation
// - Warning flashes LED, shows code, drives output
// - Warning codes A0 to A5 by cause
// - Error stops motor, flashes, shows code, faults
// - Error codes E1 to E8 by cause
// - Codes E9, EA, EL, EH, EE, EC
// - Stall beyond three seconds raises rotor lock
// - Low air four seconds running or at start
// - Panel reset button releases releasable errors
// - Reset input open-closed-open releases errors
// - E4, E5, E9, EC need power cycle
// - Four or more segments is overload warning
// - Overload allowed 30, 10, 5 seconds
// - Overload time out raises torque error
// - Emergency stop open drops relay, stops motor
`timescale 1ns/1ns
module spm_top #(
    parameter int LOAD_W = 3,
    parameter int TICK_CYC = spm_pkg::TICK_CYC
) (
    input wire logic CORE_CLK,
    input wire logic RESET,
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic [5:0] WARN_COND,
    input wire logic [13:0] ERR_COND,
    input wire logic MOTOR_STALLED,
    input wire logic MOTOR_ROTATING,
    input wire logic AIR_LOW,
    input wire logic START_CMD,
    input wire logic [LOAD_W-1:0] LOAD_SEGMENTS,
    input wire logic PANEL_RESET_BTN,
    input wire logic RESET_INPUT_CLOSED,
    input wire logic EMERGENCY_STOP_INPUT_CLOSED,
    output logic WARNING_OUT,
    output logic FAULT_OUT,
    output logic WARNING_LED,
    output logic ERROR_LED,
    output logic [7:0] DISPLAY_CODE,
    output logic MOTOR_ENABLE,
    output logic SAFETY_RELAY_ON,
    output logic IRQ
);
    typedef enum logic [1:0] {
        SPM_REL_IDLE = 2'b00,
        SPM_REL_CLOSED = 2'b01
    } spm_rel_t;

    // Two-flop synchronisers for every pin input
    localparam int NSYNC = 6 + 14 + 5 + LOAD_W + 3;
    logic [NSYNC-1:0] s1_reg;
    logic [NSYNC-1:0] s2_reg;
    wire [NSYNC-1:0] pins_raw = {WARN_COND, ERR_COND, MOTOR_STALLED, MOTOR_ROTATING, AIR_LOW,
        START_CMD, PANEL_RESET_BTN, LOAD_SEGMENTS, RESET_INPUT_CLOSED,
        EMERGENCY_STOP_INPUT_CLOSED, 1'b0};
    // Estop stage resets closed, so reset alone raises no stop error
    localparam logic [NSYNC-1:0] SYNC_IDLE = NSYNC'(2'h2);
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            s1_reg <= SYNC_IDLE;
            s2_reg <= SYNC_IDLE;
        end else begin
            s1_reg <= pins_raw;
            s2_reg <= s1_reg;
        end
    end
    wire [5:0] warn_in = s2_reg[NSYNC-1 -: 6];
    wire [13:0] err_in = s2_reg[NSYNC-7 -: 14];
    wire stalled = s2_reg[NSYNC-21];
    wire rotating = s2_reg[NSYNC-22];
    wire air_low = s2_reg[NSYNC-23];
    wire start_cmd = s2_reg[NSYNC-24];
    wire panel_btn = s2_reg[NSYNC-25];
    wire [LOAD_W-1:0] load_seg = s2_reg[LOAD_W+2 -: LOAD_W];
    wire reset_closed = s2_reg[2];
    wire estop_closed = s2_reg[1];

    // Millisecond tick divider
    logic [16:0] div_reg;
    logic tick_reg;
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            div_reg <= '0;
            tick_reg <= 1'b0;
        end else if (div_reg == 17'(TICK_CYC - 1)) begin
            div_reg <= '0;
            tick_reg <= 1'b1;
        end else begin
            div_reg <= div_reg + 17'h00001;
            tick_reg <= 1'b0;
        end
    end

    // Overload allowance by segment count
    wire overload = 32'(load_seg) >= spm_pkg::OVL_SEG_MIN;
    wire [15:0] ovl_limit = (load_seg >= LOAD_W'(6)) ? 16'(spm_pkg::OVL6_MS) :
        (load_seg == LOAD_W'(5)) ? 16'(spm_pkg::OVL5_MS) : 16'(spm_pkg::OVL4_MS);
    logic [LOAD_W-1:0] seg_prev_reg;
    // Higher count shortens the allowance; restart on any change of level
    wire ovl_run = overload && (seg_prev_reg == load_seg);
    logic ovl_expired;
    logic rotor_expired;
    logic air_expired;
    spm_ms_timer #(.W(16)) u_ovl (
        .clk(CORE_CLK), .rst(RESET), .tick(tick_reg), .run(ovl_run),
        .limit(ovl_limit), .expired(ovl_expired)
    );
    spm_ms_timer #(.W(16)) u_rotor (
        .clk(CORE_CLK), .rst(RESET), .tick(tick_reg), .run(stalled),
        .limit(16'(spm_pkg::ROTOR_LOCK_MS)), .expired(rotor_expired)
    );
    spm_ms_timer #(.W(16)) u_air (
        .clk(CORE_CLK), .rst(RESET), .tick(tick_reg), .run(air_low && rotating),
        .limit(16'(spm_pkg::LOW_AIR_MS)), .expired(air_expired)
    );

    // Start edge for the low-air-at-start check
    logic start_prev_reg;
    wire start_rise = start_cmd && !start_prev_reg;

    // Release by reset input open-closed-open, or panel button press
    spm_rel_t rel_state_reg;
    logic btn_prev_reg;
    wire pin_release = (rel_state_reg == SPM_REL_CLOSED) && !reset_closed;
    wire btn_release = panel_btn && !btn_prev_reg;
    wire release_ev = pin_release || btn_release;

    // Error detection
    logic [13:0] err_reg;
    wire [13:0] err_set = err_in
        | (14'(rotor_expired) << spm_pkg::E_ROTOR)
        | (14'(air_expired || (start_rise && air_low)) << spm_pkg::E_LOW_AIR)
        | (14'(ovl_expired) << spm_pkg::E_TORQUE)
        | (14'(!estop_closed) << spm_pkg::E_ESTOP);
    // Set wins over release; power-cycle codes never clear on release
    wire [13:0] err_keep = release_ev ? (err_reg & spm_pkg::STICKY_MASK) : err_reg;
    wire [13:0] err_next = err_keep | err_set;
    wire [5:0] warn_now = warn_in | (6'(overload) << spm_pkg::W_OVERLOAD)
        | (6'(!estop_closed) << spm_pkg::W_ESTOP);

    function automatic logic [7:0] err_code(input logic [13:0] e);
        logic [7:0] c;
        c = spm_pkg::CODE_NONE;
        for (int i = spm_pkg::NUM_ERR - 1; i >= 0; i--) begin
            if (e[i]) begin
                unique case (i)
                    spm_pkg::E_CURRENT: c = spm_pkg::CODE_E1;
                    spm_pkg::E_VOLTAGE: c = spm_pkg::CODE_E2;
                    spm_pkg::E_SENSOR: c = spm_pkg::CODE_E3;
                    spm_pkg::E_OVERHEAT: c = spm_pkg::CODE_E4;
                    spm_pkg::E_BRAKE: c = spm_pkg::CODE_E5;
                    spm_pkg::E_ROTOR: c = spm_pkg::CODE_E6;
                    spm_pkg::E_LOW_AIR: c = spm_pkg::CODE_E7;
                    spm_pkg::E_TORQUE: c = spm_pkg::CODE_E8;
                    spm_pkg::E_LINK: c = spm_pkg::CODE_E9;
                    spm_pkg::E_SEQ: c = spm_pkg::CODE_EA;
                    spm_pkg::E_MOTOR: c = spm_pkg::CODE_EL;
                    spm_pkg::E_SPEED: c = spm_pkg::CODE_EH;
                    spm_pkg::E_ESTOP: c = spm_pkg::CODE_EE;
                    default: c = spm_pkg::CODE_EC;
                endcase
            end
        end
        return c;
    endfunction

    function automatic logic [7:0] warn_code(input logic [5:0] w);
        logic [7:0] c;
        c = spm_pkg::CODE_NONE;
        for (int i = spm_pkg::NUM_WARN - 1; i >= 0; i--) begin
            if (w[i]) begin
                c = spm_pkg::CODE_WARN_BASE | 8'(i);
            end
        end
        return c;
    endfunction

    wire any_err = |err_next;
    wire any_warn = |warn_now;
    wire [7:0] code_next = any_err ? err_code(err_next) : warn_code(warn_now);

    // Flash rate for the indicators
    logic [7:0] flash_cnt_reg;
    logic flash_reg;
    logic [2:0] irq_stat_reg;
    logic [2:0] irq_mask_reg;

    // Avalon slave: one wait state per access
    logic wait_reg;
    wire acc = (AVS_READ || AVS_WRITE) && wait_reg;
    wire wr_done = AVS_WRITE && !wait_reg;
    wire [31:0] rd_mux =
        (AVS_ADDRESS == spm_pkg::ADDR_WARN) ? 32'(warn_now) :
        (AVS_ADDRESS == spm_pkg::ADDR_ERR) ? 32'(err_reg) :
        (AVS_ADDRESS == spm_pkg::ADDR_CODE) ? 32'(DISPLAY_CODE) :
        (AVS_ADDRESS == spm_pkg::ADDR_IRQ_STAT) ? 32'(irq_stat_reg) :
        (AVS_ADDRESS == spm_pkg::ADDR_IRQ_MASK) ? 32'(irq_mask_reg) : 32'h00000000;
    wire irq_clr_wr = wr_done && (AVS_ADDRESS == spm_pkg::ADDR_IRQ_STAT);
    wire [2:0] irq_ev = {release_ev, any_err && !(|err_reg), any_warn && !WARNING_OUT};
    wire [2:0] irq_stat_next = (irq_stat_reg & ~(irq_clr_wr ? AVS_WRITEDATA[2:0] : 3'h0))
        | irq_ev;

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            wait_reg <= 1'b1;
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA <= '0;
            irq_mask_reg <= spm_pkg::IRQ_MASK_RESET;
        end else begin
            wait_reg <= !acc;
            AVS_WAITREQUEST <= !acc;
            AVS_READDATA <= acc ? rd_mux : AVS_READDATA;
            if (wr_done && AVS_ADDRESS == spm_pkg::ADDR_IRQ_MASK) begin
                irq_mask_reg <= AVS_WRITEDATA[2:0];
            end
        end
    end

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            err_reg <= spm_pkg::ERR_RESET;
            rel_state_reg <= SPM_REL_IDLE;
            btn_prev_reg <= 1'b0;
            start_prev_reg <= 1'b0;
            seg_prev_reg <= '0;
            irq_stat_reg <= '0;
            IRQ <= 1'b0;
        end else begin
            err_reg <= err_next;
            btn_prev_reg <= panel_btn;
            start_prev_reg <= start_cmd;
            seg_prev_reg <= load_seg;
            irq_stat_reg <= irq_stat_next;
            IRQ <= |(irq_stat_next & irq_mask_reg);
            if (rel_state_reg == SPM_REL_IDLE && reset_closed) begin
                rel_state_reg <= SPM_REL_CLOSED;
            end else if (pin_release) begin
                rel_state_reg <= SPM_REL_IDLE;
            end
        end
    end

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            flash_cnt_reg <= '0;
            flash_reg <= 1'b0;
            WARNING_OUT <= 1'b0;
            FAULT_OUT <= 1'b0;
            WARNING_LED <= 1'b0;
            ERROR_LED <= 1'b0;
            DISPLAY_CODE <= spm_pkg::CODE_NONE;
            MOTOR_ENABLE <= 1'b0;
            SAFETY_RELAY_ON <= 1'b0;
        end else begin
            if (tick_reg) begin
                if (flash_cnt_reg == 8'(spm_pkg::FLASH_MS - 1)) begin
                    flash_cnt_reg <= '0;
                    flash_reg <= !flash_reg;
                end else begin
                    flash_cnt_reg <= flash_cnt_reg + 8'h01;
                end
            end
            WARNING_OUT <= any_warn;
            WARNING_LED <= any_warn && flash_reg;
            FAULT_OUT <= any_err;
            ERROR_LED <= any_err && flash_reg;
            DISPLAY_CODE <= code_next;
            MOTOR_ENABLE <= !any_err && estop_closed;
            SAFETY_RELAY_ON <= estop_closed;
        end
    end

    // Motor held off while any error is latched
    motor_off_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        |err_reg |-> !MOTOR_ENABLE) else $error("Motor enabled with error");
    relay_drop_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        !estop_closed |=> !SAFETY_RELAY_ON && !MOTOR_ENABLE) else $error("Relay held in stop");
    sticky_keep_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        err_reg[spm_pkg::E_OVERHEAT] |=> err_reg[spm_pkg::E_OVERHEAT])
        else $error("Power-cycle error cleared");
    fault_hold_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        FAULT_OUT && !release_ev |=> FAULT_OUT) else $error("Fault dropped");
    warn_ovl_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        overload |=> WARNING_OUT) else $error("Overload without warning");
    sequence pin_closed_s;
        reset_closed ##1 !reset_closed;
    endsequence
    pin_rel_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        pin_closed_s ##0 (err_set == 14'h0000)
        |=> (err_reg & ~spm_pkg::STICKY_MASK) == 14'h0000)
        else $error("Reset pin sequence ignored");
    torque_err_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        $rose(ovl_expired) |=> err_reg[spm_pkg::E_TORQUE]) else $error("Torque error missing");
    code_err_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        err_next == 14'h0080 |=> DISPLAY_CODE == spm_pkg::CODE_E8) else $error("Wrong E8 code");
    btn_rel_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        btn_release && err_set == 14'h0 |=> (err_reg & ~spm_pkg::STICKY_MASK) == 14'h0)
        else $error("Button did not release");
endmodule

// >>> spm_pkg.sv
// Package of the spindle protection monitor: map, codes and timing.
// Assumes a 100 MHz core clock.
package spm_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int ROTOR_LOCK_S = 3;
    localparam int LOW_AIR_S = 4;
    localparam int OVL4_S = 30;
    localparam int OVL5_S = 10;
    localparam int OVL6_S = 5;
    localparam int TICK_MS = 1;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int ROTOR_LOCK_MS = ROTOR_LOCK_S * 1000;
    localparam int LOW_AIR_MS = LOW_AIR_S * 1000;
    localparam int OVL4_MS = OVL4_S * 1000;
    localparam int OVL5_MS = OVL5_S * 1000;
    localparam int OVL6_MS = OVL6_S * 1000;
    localparam int OVL_SEG_MIN = 4;
    // Register word offsets
    localparam logic [3:0] ADDR_WARN = 4'h0;
    localparam logic [3:0] ADDR_ERR = 4'h1;
    localparam logic [3:0] ADDR_CODE = 4'h2;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h3;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h4;
    localparam logic [3:0] ADDR_CTRL = 4'h5;
    // Warning bit positions, equal to the low digit of the A code
    localparam int W_CORD = 0;
    localparam int W_LOW_AIR = 1;
    localparam int W_OVERHEAT = 2;
    localparam int W_OVERLOAD = 3;
    localparam int W_ESTOP = 4;
    localparam int W_HIGH_AIR = 5;
    localparam int NUM_WARN = 6;
    // Error bit positions
    localparam int E_CURRENT = 0;
    localparam int E_VOLTAGE = 1;
    localparam int E_SENSOR = 2;
    localparam int E_OVERHEAT = 3;
    localparam int E_BRAKE = 4;
    localparam int E_ROTOR = 5;
    localparam int E_LOW_AIR = 6;
    localparam int E_TORQUE = 7;
    localparam int E_LINK = 8;
    localparam int E_SEQ = 9;
    localparam int E_MOTOR = 10;
    localparam int E_SPEED = 11;
    localparam int E_ESTOP = 12;
    localparam int E_MEMORY = 13;
    localparam int NUM_ERR = 14;
    localparam logic [13:0] STICKY_MASK = 14'h2118;
    localparam logic [13:0] ERR_RESET = 14'h0000;
    localparam logic [5:0] WARN_RESET = 6'h00;
    // Display codes: high nibble A or E, low nibble digit or letter; 00 for no code
    localparam logic [7:0] CODE_NONE = 8'h00;
    localparam logic [7:0] CODE_WARN_BASE = 8'hA0;
    localparam logic [7:0] CODE_E1 = 8'hE1;
    localparam logic [7:0] CODE_E2 = 8'hE2;
    localparam logic [7:0] CODE_E3 = 8'hE3;
    localparam logic [7:0] CODE_E4 = 8'hE4;
    localparam logic [7:0] CODE_E5 = 8'hE5;
    localparam logic [7:0] CODE_E6 = 8'hE6;
    localparam logic [7:0] CODE_E7 = 8'hE7;
    localparam logic [7:0] CODE_E8 = 8'hE8;
    localparam logic [7:0] CODE_E9 = 8'hE9;
    localparam logic [7:0] CODE_EA = 8'hEA;
    localparam logic [7:0] CODE_EL = 8'hEB;
    localparam logic [7:0] CODE_EH = 8'hED;
    localparam logic [7:0] CODE_EE = 8'hEE;
    localparam logic [7:0] CODE_EC = 8'hEC;
    localparam int FLASH_MS = 250;
    localparam int IRQ_WARN_BIT = 0;
    localparam int IRQ_ERR_BIT = 1;
    localparam int IRQ_RELEASE_BIT = 2;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
endpackage

// >>> spm_ms_timer.sv
// Millisecond timer: counts ticks while run is high, flags when limit exceeded.
// Assumes a one-cycle tick from the top's divider.
`timescale 1ns/1ns
module spm_ms_timer #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic run,
    input wire logic [W-1:0] limit,
    output logic expired
);
    logic [W-1:0] cnt_reg;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
            expired <= 1'b0;
        end else if (!run) begin
            cnt_reg <= '0;
            expired <= 1'b0;
        end else if (tick && !expired) begin
            if (cnt_reg >= limit) begin
                expired <= 1'b1;
            end else begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end
endmodule

// >>> spm_ctrl_model.sv
// Model of the external machine controller on the connector pins.
// Assumes its tasks are called from the bench just after a clock edge.
`timescale 1ns/1ns
module spm_ctrl_model (
    input wire logic clk,
    input wire logic fault_in,
    output logic start_cmd,
    output logic reset_closed,
    output logic estop_closed
);
    initial begin
        start_cmd = 1'b0;
        reset_closed = 1'b0;
        estop_closed = 1'b1;
    end
    // Ends between edges so callers look at settled outputs
    task automatic hold();
        repeat (8) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic release_seq();
        @(posedge clk) reset_closed <= 1'b0;
        hold();
        @(posedge clk) reset_closed <= 1'b1;
        hold();
        @(posedge clk) reset_closed <= 1'b0;
        hold();
    endtask
    task automatic start_set(input logic v);
        @(posedge clk) start_cmd <= v;
        hold();
    endtask
    // Start recycled once the fault has gone
    task automatic restart();
        if (fault_in === 1'b0 && start_cmd === 1'b1) begin
            start_set(1'b0);
            start_set(1'b1);
        end
    endtask
    task automatic estop_set(input logic closed);
        @(posedge clk) estop_closed <= closed;
        hold();
    endtask
endmodule

// >>> test_spm_top.sv
// Self-checking bench of the spindle protection monitor.
// Assumes a controller model in spm_ctrl_model and a 100 MHz clock.
`timescale 1ns/1ns
`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
    $display("wrong value %s expected %0h seen %0h", what, exp, got); end end
module test_spm_top;
    localparam logic [13:0] keep = 14'h2118;
    localparam logic [7:0] ecode [14] = '{8'hE1, 8'hE2, 8'hE3, 8'hE4, 8'hE5, 8'hE6, 8'hE7,
        8'hE8, 8'hE9, 8'hEA, spm_pkg::CODE_EL, spm_pkg::CODE_EH, 8'hEE, 8'hEC};
    logic clk, rst, rd, wr, air_low, panel_btn;
    logic [3:0] adr;
    logic [31:0] wdat, rdat;
    logic wreq, warn_out, fault_out, motor_en, relay_on, irq;
    logic stalled, rotating, warn_led, err_led;
    // One tick a cycle so the long allowances fit the run
    localparam int TICK = 1;
    logic start_cmd, reset_closed, estop_closed;
    logic [5:0] warn_cond;
    logic [13:0] err_cond;
    logic [2:0] load_seg;
    logic [7:0] code;
    int mismatches = 0;
    int n_compared = 0;
    spm_top #(.TICK_CYC(TICK)) spm_top_inst (.CORE_CLK(clk), .RESET(rst), .AVS_ADDRESS(adr),
        .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat),
        .AVS_WAITREQUEST(wreq), .WARN_COND(warn_cond), .ERR_COND(err_cond),
        .MOTOR_STALLED(stalled), .MOTOR_ROTATING(rotating), .AIR_LOW(air_low),
        .START_CMD(start_cmd), .LOAD_SEGMENTS(load_seg), .PANEL_RESET_BTN(panel_btn),
        .RESET_INPUT_CLOSED(reset_closed), .EMERGENCY_STOP_INPUT_CLOSED(estop_closed),
        .WARNING_OUT(warn_out), .FAULT_OUT(fault_out), .WARNING_LED(warn_led),
        .ERROR_LED(err_led), .DISPLAY_CODE(code), .MOTOR_ENABLE(motor_en),
        .SAFETY_RELAY_ON(relay_on), .IRQ(irq));
    spm_ctrl_model spm_ctrl_model_inst (.clk(clk), .fault_in(fault_out),
        .start_cmd(start_cmd), .reset_closed(reset_closed), .estop_closed(estop_closed));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic settle();
        repeat (8) @(posedge clk);
        @(negedge clk);
    endtask
    // Holds the request until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk);
        adr <= a;
        wdat <= d;
        rd <= ~w;
        wr <= w;
        @(posedge clk);
        while (wreq !== 1'b0) begin
            @(posedge clk);
        end
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e, input string nm);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        `CHK(nm, e, q)
    endtask
    task automatic power_cycle();
        @(posedge clk) rst <= 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        settle();
    endtask
    task automatic release_err(input logic by_line);
        if (by_line) begin
            spm_ctrl_model_inst.release_seq();
        end else begin
            @(posedge clk) panel_btn <= 1'b1;
            settle();
            @(posedge clk) panel_btn <= 1'b0;
        end
        settle();
    endtask
    task automatic t_reset();
        for (int a = 0; a < 7; a++) begin
            rd_chk((a == 6) ? 4'hF : 4'(a), 32'h0, "reset register");
        end
        `CHK("relay", 1'b1, relay_on)
        `CHK("fault", 1'b0, fault_out)
    endtask
    task automatic t_irq();
        wr_reg(spm_pkg::ADDR_IRQ_MASK, 32'h1);
        @(posedge clk) warn_cond <= 6'h04;
        settle();
        `CHK("irq raised", 1'b1, irq)
        rd_chk(spm_pkg::ADDR_IRQ_STAT, 32'h1, "irq status");
        wr_reg(spm_pkg::ADDR_IRQ_MASK, 32'h0);
        settle();
        `CHK("irq masked", 1'b0, irq)
        wr_reg(spm_pkg::ADDR_IRQ_MASK, 32'h1);
        @(posedge clk) warn_cond <= 6'h00;
        settle();
        wr_reg(spm_pkg::ADDR_IRQ_STAT, 32'h1);
        settle();
        `CHK("irq cleared", 1'b0, irq)
        rd_chk(spm_pkg::ADDR_IRQ_STAT, 32'h0, "irq status");
        wr_reg(spm_pkg::ADDR_ERR, 32'h3FFF);
        rd_chk(spm_pkg::ADDR_ERR, 32'h0, "read-only errors");
    endtask
    task automatic t_warn();
        for (int i = 0; i < 6; i++) begin
            @(posedge clk) warn_cond <= 6'(1 << i);
            settle();
            `CHK("warning out", 1'b1, warn_out)
            `CHK("warning code", 8'hA0 + 8'(i), code)
            rd_chk(spm_pkg::ADDR_WARN, 32'(1 << i), "warning reg");
        end
        flash_chk(1'b0, "warning led");
        @(posedge clk) warn_cond <= 6'h00;
        settle();
        `CHK("warning out", 1'b0, warn_out)
    endtask
    task automatic t_overload();
        for (int s = 3; s < 8; s++) begin
            @(posedge clk) load_seg <= 3'(s);
            settle();
            `CHK("overload warning", (s >= 4) ? 1'b1 : 1'b0, warn_out)
            `CHK("overload code", (s >= 4) ? 8'hA3 : 8'h00, code)
        end
        @(posedge clk) load_seg <= 3'h0;
        settle();
    endtask
    task automatic t_errors();
        for (int i = 0; i < 14; i++) begin
            @(posedge clk) err_cond <= 14'(1 << i);
            settle();
            `CHK("fault out", 1'b1, fault_out)
            `CHK("motor enable", 1'b0, motor_en)
            `CHK("error code", ecode[i], code)
            rd_chk(spm_pkg::ADDR_ERR, 32'(1 << i), "error reg");
            @(posedge clk) err_cond <= 14'h0;
            settle();
            `CHK("fault held", 1'b1, fault_out)
            release_err(i[0]);
            `CHK("fault after release", keep[i], fault_out)
            if (keep[i]) begin
                power_cycle();
            end
        end
    endtask
    task automatic t_estop();
        spm_ctrl_model_inst.start_set(1'b1);
        `CHK("motor running", 1'b1, motor_en)
        spm_ctrl_model_inst.estop_set(1'b0);
        `CHK("relay dropped", 1'b0, relay_on)
        `CHK("motor stopped", 1'b0, motor_en)
        `CHK("estop code", 8'hEE, code)
        spm_ctrl_model_inst.estop_set(1'b1);
        release_err(1'b1);
        `CHK("fault released", 1'b0, fault_out)
        spm_ctrl_model_inst.restart();
        `CHK("motor restarted", 1'b1, motor_en)
        rd_chk(spm_pkg::ADDR_IRQ_STAT, 32'h7, "irq events");
        spm_ctrl_model_inst.start_set(1'b0);
    endtask
    task automatic t_low_air();
        @(posedge clk) air_low <= 1'b1;
        settle();
        spm_ctrl_model_inst.start_set(1'b1);
        `CHK("low air fault", 1'b1, fault_out)
        `CHK("low air code", 8'hE7, code)
        spm_ctrl_model_inst.start_set(1'b0);
        @(posedge clk) air_low <= 1'b0;
        release_err(1'b0);
        `CHK("low air released", 1'b0, fault_out)
    endtask
    // Indicator must both light and go dark while its cause stands
    task automatic flash_chk(input logic err, input string nm);
        int hi;
        hi = 0;
        repeat (600) @(negedge clk) hi += err ? err_led : warn_led;
        `CHK(nm, 1'b1, hi > 0 && hi < 600)
    endtask
    // Cause applied at the last edge; error must wait out its allowance
    task automatic expire_chk(input int ms, input logic [7:0] e);
        repeat (ms * TICK - 10) @(posedge clk);
        @(negedge clk);
        `CHK("within allowance", 1'b0, fault_out)
        repeat (20) @(posedge clk);
        @(negedge clk);
        `CHK("timed error", 1'b1, fault_out)
        `CHK("timed code", e, code)
        flash_chk(1'b1, "error led");
        @(posedge clk) {stalled, rotating, air_low, load_seg} <= 6'h00;
        release_err(1'b0);
        `CHK("timed release", 1'b0, fault_out)
    endtask
    task automatic t_timers();
        @(posedge clk) stalled <= 1'b1;
        expire_chk(spm_pkg::ROTOR_LOCK_MS, spm_pkg::CODE_E6);
        @(posedge clk) {air_low, rotating} <= 2'h3;
        expire_chk(spm_pkg::LOW_AIR_MS, spm_pkg::CODE_E7);
        @(posedge clk) load_seg <= 3'h6;
        repeat (spm_pkg::OVL6_MS * TICK / 2) @(posedge clk);
        load_seg <= 3'h3;
        settle();
        @(posedge clk) load_seg <= 3'h6;
        expire_chk(spm_pkg::OVL6_MS, spm_pkg::CODE_E8);
        @(posedge clk) load_seg <= 3'h5;
        expire_chk(spm_pkg::OVL5_MS, spm_pkg::CODE_E8);
    endtask
    initial begin
        rst = 1'b1;
        rd = 1'b0;
        wr = 1'b0;
        adr = 4'h0;
        wdat = 32'h0;
        warn_cond = 6'h00;
        err_cond = 14'h0000;
        air_low = 1'b0;
        stalled = 1'b0;
        rotating = 1'b0;
        load_seg = 3'h0;
        panel_btn = 1'b0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        settle();
        t_reset();
        t_irq();
        t_warn();
        t_overload();
        t_errors();
        t_estop();
        t_low_air();
        t_timers();
        close_out();
    end
    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        close_out();
    end
endmodule
